// ===== rtl/hpp_pkg.sv
/*
 * Constants for the board side of the byte-wide host handshake port:
 * local register map, field positions, reset values and timing counts.
 * Assumes a 125 MHz local clock.
 */
package hpp_pkg;
	localparam int unsigned CLK_MHZ           = 125;
	localparam int unsigned RESET_HOLD_US     = 26;
	// a least time, so rounded up
	localparam int unsigned RESET_HOLD_CYCLES = (RESET_HOLD_US * 1000 + (1000 / CLK_MHZ) - 1) / (1000 / CLK_MHZ);

	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [3:0] ADDR_RXDATA = 4'h2;
	localparam logic [3:0] ADDR_TXDATA = 4'h3;
	localparam logic [3:0] ADDR_SVCODE = 4'h4;

	// control register fields: write 1 to act, except CTRL_AUTO_BIT, which holds the value written
	localparam int unsigned CTRL_WR_ACK_BIT  = 0;
	localparam int unsigned CTRL_SEND_BIT    = 1;
	localparam int unsigned CTRL_IRQ_BIT     = 2;
	localparam int unsigned CTRL_ABORT_CLR   = 3;
	localparam int unsigned CTRL_AUTO_BIT    = 4;

	// status register fields
	localparam int unsigned STAT_HOST_WREQ   = 0;
	localparam int unsigned STAT_WR_ACK      = 1;
	localparam int unsigned STAT_SEND_REQ    = 2;
	localparam int unsigned STAT_HOST_RACK   = 3;
	localparam int unsigned STAT_IRQ_REQ     = 4;
	localparam int unsigned STAT_ATTN        = 5;
	localparam int unsigned STAT_ABORT       = 6;
	localparam int unsigned STAT_SELECTED    = 7;
	localparam int unsigned STAT_RX_VALID    = 8;

	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [4:0] CTRL_RESET = 5'h10;
endpackage : hpp_pkg

// ===== rtl/hpp_sync.sv
/*
 * Two-stage synchroniser for a bus of independent level inputs.
 * Assumes each bit is a slow handshake level; no bus coherence implied.
 */
`timescale 1ns/100ps
module hpp_sync #(
	parameter int unsigned WIDTH = 1
) (
	// clocking
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic             clk_en,
	// levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage1_next;
	logic [WIDTH-1:0] stage2_next;

	always_comb begin
		stage1_next = stage1_reg;
		stage2_next = sync_out;
		if (clk_en) begin
			stage1_next = async_in;
			stage2_next = stage1_reg;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			stage1_reg <= '0;
			sync_out   <= '0;
		end else begin
			stage1_reg <= stage1_next;
			sync_out   <= stage2_next;
		end
	end
endmodule : hpp_sync

// ===== rtl/hpp_hold_timer.sv
/*
 * Counts how long a qualified level has been held; fires once when it
 * has stayed high for HOLD_CYCLES. Assumes synchronous level input.
 */
`timescale 1ns/100ps
module hpp_hold_timer #(
	parameter int unsigned HOLD_CYCLES = hpp_pkg::RESET_HOLD_CYCLES
) (
	// clocking
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic clk_en,
	// level and result
	input  wire logic level_in,
	output logic      expired
);
	localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);
	localparam logic [CW-1:0] LIMIT = CW'(HOLD_CYCLES);

	logic [CW-1:0] count_reg;
	logic [CW-1:0] count_next;
	logic          expired_next;

	always_comb begin
		count_next   = count_reg;
		expired_next = expired;
		if (clk_en) begin
			expired_next = 1'b0;
			if (!level_in) begin
				count_next = '0;
			end else if (count_reg != LIMIT) begin
				count_next = count_reg + CW'(1);
				expired_next = (count_reg + CW'(1)) == LIMIT;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			count_reg <= '0;
			expired   <= 1'b0;
		end else begin
			count_reg <= count_next;
			expired   <= expired_next;
		end
	end
endmodule : hpp_hold_timer

// ===== rtl/hpp_board_port.sv
/*
 * Board side of the byte-wide asynchronous host handshake port: host-to-
 * board and board-to-host byte handshakes, board interrupt with shared
 * attention line, host abort latch and host reset, single or broadcast.
 * Assumes host lines are asynchronous and are synchronised here; the
 * local processor reaches the block over a plain register port.
 */
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/100ps
module hpp_board_port #(
	parameter int unsigned DATA_W      = 8,
	parameter int unsigned SEL_W       = 3,
	parameter int unsigned RESET_HOLD  = hpp_pkg::RESET_HOLD_CYCLES
) (
	// clocking
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic              clk_en,
	// board address switch
	input  wire logic [SEL_W-1:0]  board_id_switch,
	// host port inputs
	input  wire logic [SEL_W-1:0]  board_select_code,
	input  wire logic              host_write_request,
	input  wire logic              host_read_acknowledge,
	input  wire logic              host_irq_acknowledge,
	input  wire logic              host_abort_pulse,
	input  wire logic              host_board_reset,
	input  wire logic              broadcast_all_boards,
	input  wire logic [DATA_W-1:0] port_data_in,
	// host port outputs
	output logic [DATA_W-1:0]      port_data_out,
	output logic                   port_data_oe_n,
	output logic                   board_write_acknowledge,
	output logic                   board_send_request,
	output logic                   board_irq_request,
	output logic                   shared_attention_n_out,
	output logic                   shared_attention_n_oe_n,
	// local processor side
	output logic                   abort_irq7,
	output logic                   board_reset_out,
	// register port
	input  wire logic [3:0]        reg_addr,
	input  wire logic [15:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [15:0]            reg_rdata
);
	localparam int unsigned NSYNC = SEL_W + 6;

	logic [NSYNC-1:0]  sync_q;
	logic [SEL_W-1:0]  sel_s;
	logic              wreq_s, rack_s, iack_s, abort_s, reset_s, all_s;
	logic              selected, reset_fire, wr_ctrl;
	logic [DATA_W-1:0] data_sync;

	hpp_sync #(.WIDTH(NSYNC)) u_sync_ctl (
		.core_clk (core_clk),
		.rst      (rst),
		.clk_en   (clk_en),
		.async_in ({board_select_code, host_write_request, host_read_acknowledge,
		            host_irq_acknowledge, host_abort_pulse, host_board_reset, broadcast_all_boards}),
		.sync_out (sync_q)
	);
	hpp_sync #(.WIDTH(DATA_W)) u_sync_data (
		.core_clk (core_clk),
		.rst      (rst),
		.clk_en   (clk_en),
		.async_in (port_data_in),
		.sync_out (data_sync)
	);

	assign {sel_s, wreq_s, rack_s, iack_s, abort_s, reset_s, all_s} = sync_q;
	assign selected = (sel_s == board_id_switch);

	hpp_hold_timer #(.HOLD_CYCLES(RESET_HOLD)) u_reset_hold (
		.core_clk (core_clk),
		.rst      (rst),
		.clk_en   (clk_en),
		.level_in (reset_s & (selected | all_s)),
		.expired  (reset_fire)
	);

	typedef enum logic [1:0] {
		HPP_WR_IDLE = 2'b00,
		HPP_WR_ACK  = 2'b01,
		HPP_WR_DONE = 2'b11
	} hpp_wr_e;

	typedef enum logic [1:0] {
		HPP_TX_IDLE = 2'b00,
		HPP_TX_REQ  = 2'b01,
		HPP_TX_DRV  = 2'b11
	} hpp_tx_e;

	hpp_wr_e           wr_state_reg, wr_state_next;
	hpp_tx_e           tx_state_reg, tx_state_next;
	logic [DATA_W-1:0] rx_data_reg, rx_data_next;
	logic              rx_valid_reg, rx_valid_next;
	logic [DATA_W-1:0] tx_data_reg, tx_data_next;
	logic [DATA_W-1:0] sv_code_reg, sv_code_next;
	logic              auto_ack_reg, auto_ack_next;
	logic              sw_ack_reg, sw_ack_next;
	logic              irq_pend_reg, irq_pend_next;
	logic              attn_reg, attn_next;
	logic              abort_reg, abort_next;
	logic              abort_d_reg;
	logic              is_svc_reg, is_svc_next;
	logic [15:0]       rdata_next, status;

	assign wr_ctrl = clk_en & reg_wr & (reg_addr == hpp_pkg::ADDR_CTRL);

	always_comb begin
		status = '0;
		status[hpp_pkg::STAT_HOST_WREQ] = wreq_s;
		status[hpp_pkg::STAT_WR_ACK]    = (wr_state_reg == HPP_WR_ACK);
		status[hpp_pkg::STAT_SEND_REQ]  = (tx_state_reg == HPP_TX_REQ);
		status[hpp_pkg::STAT_HOST_RACK] = rack_s;
		status[hpp_pkg::STAT_IRQ_REQ]   = irq_pend_reg;
		status[hpp_pkg::STAT_ATTN]      = attn_reg;
		status[hpp_pkg::STAT_ABORT]     = abort_reg;
		status[hpp_pkg::STAT_SELECTED]  = selected;
		status[hpp_pkg::STAT_RX_VALID]  = rx_valid_reg;
	end

	always_comb begin
		wr_state_next = wr_state_reg;
		tx_state_next = tx_state_reg;
		rx_data_next  = rx_data_reg;
		rx_valid_next = rx_valid_reg;
		tx_data_next  = tx_data_reg;
		sv_code_next  = sv_code_reg;
		auto_ack_next = auto_ack_reg;
		sw_ack_next   = sw_ack_reg;
		irq_pend_next = irq_pend_reg;
		attn_next     = attn_reg;
		abort_next    = abort_reg;
		is_svc_next   = is_svc_reg;
		rdata_next    = reg_rdata;
		if (clk_en) begin
			rdata_next = '0;
			if (reg_rd) begin
				unique case (reg_addr)
					hpp_pkg::ADDR_CTRL:   rdata_next = {11'h000, auto_ack_reg, 4'h0};
					hpp_pkg::ADDR_STATUS: rdata_next = status;
					hpp_pkg::ADDR_RXDATA: rdata_next = 16'(rx_data_reg);
					hpp_pkg::ADDR_TXDATA: rdata_next = 16'(tx_data_reg);
					hpp_pkg::ADDR_SVCODE: rdata_next = 16'(sv_code_reg);
					default:              rdata_next = '0;
				endcase
				if (reg_addr == hpp_pkg::ADDR_RXDATA) begin
					rx_valid_next = 1'b0;
				end
			end
			if (reg_wr && reg_addr == hpp_pkg::ADDR_TXDATA && tx_state_reg == HPP_TX_IDLE) begin
				tx_data_next = reg_wdata[DATA_W-1:0];
			end
			if (reg_wr && reg_addr == hpp_pkg::ADDR_SVCODE && !attn_reg) begin
				sv_code_next = reg_wdata[DATA_W-1:0];
			end
			if (wr_ctrl) begin
				auto_ack_next = reg_wdata[hpp_pkg::CTRL_AUTO_BIT];
				if (reg_wdata[hpp_pkg::CTRL_WR_ACK_BIT]) begin
					sw_ack_next = 1'b1;
				end
			end
			// host-to-board byte: capture then acknowledge
			unique case (wr_state_reg)
				HPP_WR_IDLE: begin
					if (selected && wreq_s) begin
						rx_data_next  = data_sync;
						rx_valid_next = 1'b1;
						wr_state_next = HPP_WR_DONE;
					end
				end
				HPP_WR_DONE: begin
					if (auto_ack_reg || sw_ack_reg) begin
						sw_ack_next   = 1'b0;
						wr_state_next = HPP_WR_ACK;
					end
				end
				HPP_WR_ACK: begin
					if (!wreq_s) begin
						wr_state_next = HPP_WR_IDLE;
					end
				end
				default: wr_state_next = HPP_WR_IDLE;
			endcase
			// board-to-host byte or service code
			unique case (tx_state_reg)
				HPP_TX_IDLE: begin
					if (wr_ctrl && reg_wdata[hpp_pkg::CTRL_SEND_BIT]) begin
						is_svc_next   = 1'b0;
						tx_state_next = HPP_TX_REQ;
					end else if (attn_reg && !is_svc_reg) begin
						is_svc_next   = 1'b1;
						tx_state_next = HPP_TX_REQ;
					end
				end
				HPP_TX_REQ: begin
					if (selected && rack_s) begin
						tx_state_next = HPP_TX_DRV;
					end
				end
				HPP_TX_DRV: begin
					if (!rack_s) begin
						tx_state_next = HPP_TX_IDLE;
					end
				end
				default: tx_state_next = HPP_TX_IDLE;
			endcase
			// board interrupt to host
			if (wr_ctrl && reg_wdata[hpp_pkg::CTRL_IRQ_BIT] && !irq_pend_reg) begin
				irq_pend_next = 1'b1;
				attn_next     = 1'b1;
				is_svc_next   = 1'b0; // code offered once per interrupt
			end else if (selected && iack_s) begin
				attn_next     = 1'b0;
				irq_pend_next = 1'b0;
			end
			// abort latch: set wins over software clear
			if (wr_ctrl && reg_wdata[hpp_pkg::CTRL_ABORT_CLR]) begin
				abort_next = 1'b0;
			end
			if (abort_s && !abort_d_reg && (selected || all_s)) begin
				abort_next = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wr_state_reg <= HPP_WR_IDLE;
			tx_state_reg <= HPP_TX_IDLE;
			rx_data_reg  <= hpp_pkg::DATA_RESET;
			rx_valid_reg <= 1'b0;
			tx_data_reg  <= hpp_pkg::DATA_RESET;
			sv_code_reg  <= hpp_pkg::DATA_RESET;
			auto_ack_reg <= hpp_pkg::CTRL_RESET[hpp_pkg::CTRL_AUTO_BIT];
			sw_ack_reg   <= 1'b0;
			irq_pend_reg <= 1'b0;
			attn_reg     <= 1'b0;
			abort_reg    <= 1'b0;
			abort_d_reg  <= 1'b0;
			is_svc_reg   <= 1'b0;
			reg_rdata    <= '0;
		end else begin
			wr_state_reg <= wr_state_next;
			tx_state_reg <= tx_state_next;
			rx_data_reg  <= rx_data_next;
			rx_valid_reg <= rx_valid_next;
			tx_data_reg  <= tx_data_next;
			sv_code_reg  <= sv_code_next;
			auto_ack_reg <= auto_ack_next;
			sw_ack_reg   <= sw_ack_next;
			irq_pend_reg <= irq_pend_next;
			attn_reg     <= attn_next;
			abort_reg    <= abort_next;
			abort_d_reg  <= clk_en ? abort_s : abort_d_reg;
			is_svc_reg   <= is_svc_next;
			reg_rdata    <= rdata_next;
		end
	end

	// registered port outputs; gated by selection where the port demands
	logic [DATA_W-1:0] pdo_next;
	logic              pdoe_n_next, wack_next, sreq_next, ireq_next, attn_oe_n_next, brst_next;

	always_comb begin
		pdo_next       = port_data_out;
		pdoe_n_next    = port_data_oe_n;
		wack_next      = board_write_acknowledge;
		sreq_next      = board_send_request;
		ireq_next      = board_irq_request;
		attn_oe_n_next = shared_attention_n_oe_n;
		brst_next      = board_reset_out;
		if (clk_en) begin
			pdo_next       = is_svc_next ? sv_code_next : tx_data_next;
			pdoe_n_next    = !(tx_state_next == HPP_TX_DRV && rack_s && selected);
			wack_next      = (wr_state_next == HPP_WR_ACK) && selected;
			sreq_next      = (tx_state_next == HPP_TX_REQ) && !is_svc_next && selected;
			ireq_next      = irq_pend_next && selected;
			attn_oe_n_next = !attn_next;
			brst_next      = reset_fire ? 1'b1 : (reset_s ? board_reset_out : 1'b0);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			port_data_out           <= hpp_pkg::DATA_RESET;
			port_data_oe_n          <= 1'b1;
			board_write_acknowledge <= 1'b0;
			board_send_request      <= 1'b0;
			board_irq_request       <= 1'b0;
			shared_attention_n_out  <= 1'b0;
			shared_attention_n_oe_n <= 1'b1;
			abort_irq7              <= 1'b0;
			board_reset_out         <= 1'b0;
		end else begin
			port_data_out           <= pdo_next;
			port_data_oe_n          <= pdoe_n_next;
			board_write_acknowledge <= wack_next;
			board_send_request      <= sreq_next;
			board_irq_request       <= ireq_next;
			shared_attention_n_out  <= 1'b0;
			shared_attention_n_oe_n <= attn_oe_n_next;
			abort_irq7              <= abort_next;
			board_reset_out         <= brst_next;
		end
	end
endmodule : hpp_board_port

// ===== sim/hpp_board_port_properties.sv
/* Port assertions for the board side of the host handshake port.
   Assumes the host holds select lines steady through each handshake. */
`timescale 1ns/100ps
module hpp_board_port_checker #(
	parameter int unsigned RESET_HOLD = 20
) (
	// clocking
	input wire logic        core_clk,
	input wire logic        rst,
	// host lines
	input wire logic [2:0]  board_id_switch,
	input wire logic [2:0]  board_select_code,
	input wire logic        host_write_request,
	input wire logic        host_read_acknowledge,
	input wire logic        host_irq_acknowledge,
	input wire logic        host_abort_pulse,
	input wire logic        host_board_reset,
	input wire logic        broadcast_all_boards,
	// board lines
	input wire logic        port_data_oe_n,
	input wire logic        board_write_acknowledge,
	input wire logic        board_send_request,
	input wire logic        board_irq_request,
	input wire logic        shared_attention_n_out,
	input wire logic        shared_attention_n_oe_n,
	input wire logic        abort_irq7,
	input wire logic        board_reset_out,
	// register port
	input wire logic [3:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr
);
	logic        sel;
	logic [15:0] hold_reg;
	logic [15:0] hold_next;
	assign sel = board_select_code == board_id_switch;
	// cycles the qualified reset line has been held
	always_comb begin
		hold_next = 16'h0000;
		if (host_board_reset && (sel || broadcast_all_boards))
			hold_next = (hold_reg == 16'hffff) ? hold_reg : hold_reg + 16'h0001;
	end
	always_ff @(posedge core_clk) begin
		hold_reg <= rst ? 16'h0000 : hold_next;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_off;
		!sel [*4];
	endsequence
	sequence s_abort;
		$rose(host_abort_pulse) && (sel || broadcast_all_boards)
		##1 (host_abort_pulse && (sel || broadcast_all_boards)) [*2];
	endsequence
	property p_attn_oc;
		shared_attention_n_out == 1'b0;
	endproperty
	property p_ack_cause;
		$rose(board_write_acknowledge) |-> host_write_request && sel;
	endproperty
	property p_ack_hold;
		board_write_acknowledge && host_write_request |=> board_write_acknowledge;
	endproperty
	property p_req_gate;
		s_off |-> !board_send_request && !board_irq_request;
	endproperty
	property p_rack_drop;
		host_read_acknowledge [*4] |-> !board_send_request;
	endproperty
	property p_data_end;
		$fell(host_read_acknowledge) |-> ##[1:6] port_data_oe_n;
	endproperty
	property p_iack_clr;
		(host_irq_acknowledge && sel) [*5] |-> shared_attention_n_oe_n && !board_irq_request;
	endproperty
	property p_abort_set;
		s_abort |-> ##[1:4] abort_irq7;
	endproperty
	property p_abort_keep;
		abort_irq7 && !(reg_wr && reg_addr == hpp_pkg::ADDR_CTRL && reg_wdata[hpp_pkg::CTRL_ABORT_CLR])
		|=> abort_irq7;
	endproperty
	property p_reset_min;
		$rose(board_reset_out) |-> hold_reg >= RESET_HOLD;
	endproperty
	property p_reset_max;
		hold_reg == RESET_HOLD + 8 |-> board_reset_out;
	endproperty
	a_attn_oc: assert property (p_attn_oc) else $error("attention output not low");
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
	a_req_gate: assert property (p_req_gate) else $error("request shown unselected");
	a_rack_drop: assert property (p_rack_drop) else $error("send request kept");
	a_data_end: assert property (p_data_end) else $error("data drive kept");
	a_iack_clr: assert property (p_iack_clr) else $error("irq not cleared");
	a_abort_set: assert property (p_abort_set) else $error("abort not latched");
	a_abort_keep: assert property (p_abort_keep) else $error("abort lost");
	a_reset_min: assert property (p_reset_min) else $error("reset too soon");
	a_reset_max: assert property (p_reset_max) else $error("reset missing");
endmodule : hpp_board_port_checker

bind hpp_board_port hpp_board_port_checker #(.RESET_HOLD(RESET_HOLD)) chk (.*);

// ===== sim/hpp_host_model.sv
/* Host adapter model: select, byte write, byte read, interrupt service.
   Assumes the bench calls one task at a time. */
`timescale 1ns/100ps
module hpp_host_model (
	// clocking
	input wire logic       core_clk,
	// host lines
	output logic [2:0]     board_select_code,
	output logic           host_write_request,
	output logic           host_read_acknowledge,
	output logic           host_irq_acknowledge,
	output logic [7:0]     port_data_in,
	// board lines
	input wire logic [7:0] port_data_out,
	input wire logic       port_data_oe_n,
	input wire logic       board_write_acknowledge,
	input wire logic       board_send_request,
	input wire logic       board_irq_request,
	input wire logic       attention_n,
	// result
	output logic           got_vld,
	output logic [7:0]     got_byte,
	output logic           fault
);
	initial begin
		board_select_code = 3'h0;
		host_write_request = 1'b0;
		host_read_acknowledge = 1'b0;
		host_irq_acknowledge = 1'b0;
		port_data_in = 8'h00;
		got_vld = 1'b0;
		got_byte = 8'h00;
		fault = 1'b0;
	end
	// bounded poll of a board line, no fixed timing assumed
	task automatic wait_lvl(input int which, input logic lvl);
		int   n;
		logic v;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
			case (which)
				0: v = board_write_acknowledge;
				1: v = board_send_request;
				2: v = port_data_oe_n;
				3: v = attention_n;
				default: v = board_irq_request;
			endcase
		end while (v !== lvl && n < 60);
		if (v !== lvl)
			fault <= 1'b1;
	endtask : wait_lvl
	task automatic pick(input logic [2:0] s);
		board_select_code <= s;
		@(posedge core_clk);
	endtask : pick
	task automatic host_write(input logic [2:0] s, input logic [7:0] b, input logic ack);
		port_data_in <= ~b;
		pick(s);
		host_write_request <= 1'b1;
		port_data_in <= b;
		if (ack)
			wait_lvl(0, 1'b1);
		else
			repeat (20) @(posedge core_clk);
		host_write_request <= 1'b0;
		port_data_in <= ~b;
		if (ack)
			wait_lvl(0, 1'b0);
	endtask : host_write
	task automatic host_read(input logic [2:0] s, input logic need);
		pick(s);
		if (need)
			wait_lvl(1, 1'b1);
		host_read_acknowledge <= 1'b1;
		wait_lvl(2, 1'b0);
		got_byte <= port_data_out;
		got_vld <= 1'b1;
		@(posedge core_clk);
		got_vld <= 1'b0;
		host_read_acknowledge <= 1'b0;
		wait_lvl(2, 1'b1);
	endtask : host_read
	task automatic host_service(input logic [2:0] s);
		wait_lvl(3, 1'b0);
		pick(s);
		wait_lvl(4, 1'b1);
		host_read(s, 1'b0);
		host_irq_acknowledge <= 1'b1;
		wait_lvl(4, 1'b0);
		repeat (4) @(posedge core_clk);
		host_irq_acknowledge <= 1'b0;
	endtask : host_service
endmodule : hpp_host_model

// ===== sim/tb_top.sv
/* Self-checking bench for the board port with a host model.
   Assumes a single board with switch address 5. */
`timescale 1ns/100ps
module tb_top;
	typedef struct {
		string       nm;
		logic [15:0] e;
		logic [15:0] m;
	} hpp_note_s;
	logic        core_clk, rst, reg_wr, reg_rd, host_abort_pulse, host_board_reset, broadcast_all_boards;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, probe_val;
	logic [2:0]  board_select_code;
	logic        host_write_request, host_read_acknowledge, host_irq_acknowledge, port_data_oe_n;
	logic [7:0]  port_data_in, port_data_out, got_byte, b;
	logic        board_write_acknowledge, board_send_request, board_irq_request, abort_irq7;
	logic        shared_attention_n_out, shared_attention_n_oe_n, board_reset_out;
	logic        attn, got_vld, fault, probe_vld, rd_d, clk_en;
	logic [31:0] seed;
	hpp_note_s   notes[$];
	int          bad_count, checks_done, i;
	hpp_board_port #(.RESET_HOLD(20)) DUT (.board_id_switch(3'h5), .*);
	hpp_host_model host (.attention_n(attn), .*);
	// open collector with pull-up
	assign attn = shared_attention_n_oe_n ? 1'b1 : shared_attention_n_out;
	initial core_clk = 1'b0;
	always #4 core_clk = ~core_clk;
	function automatic logic [7:0] rnd8();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction : rnd8
	task automatic give_verdict();
		if (bad_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict
	task automatic note(input string nm, input logic [15:0] e, input logic [15:0] m);
		hpp_note_s n;
		n.nm = nm;
		n.e = e;
		n.m = m;
		notes.push_back(n);
	endtask : note
	task automatic cmp(input logic [15:0] v);
		hpp_note_s n;
		checks_done++;
		if (notes.size() == 0) begin
			bad_count++;
			$display("CHECK FAILED unexpected expected none seen %h", v);
		end else begin
			n = notes.pop_front();
			if ((v & n.m) !== (n.e & n.m)) begin
				bad_count++;
				$display("CHECK FAILED %s expected %h seen %h", n.nm, n.e & n.m, v & n.m);
			end
		end
	endtask : cmp
	task automatic look(input string nm, input logic [15:0] e, input logic [15:0] v);
		note(nm, e, 16'hffff);
		probe_val <= v;
		probe_vld <= 1'b1;
		@(posedge core_clk);
		probe_vld <= 1'b0;
		@(posedge core_clk);
	endtask : look
	task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask : reg_write
	task automatic reg_read(input logic [3:0] a, input string nm, input logic [15:0] e, input logic [15:0] m);
		note(nm, e, m);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
	endtask : reg_read
	always @(posedge core_clk) begin
		if (rd_d)
			cmp(reg_rdata);
		if (probe_vld)
			cmp(probe_val);
		if (got_vld)
			cmp({8'h00, got_byte});
		rd_d <= reg_rd;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		bad_count++;
		give_verdict();
	end
	initial begin
		seed = 32'd9106;
		rst <= 1'b1;
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		reg_addr <= 4'h0;
		reg_wdata <= 16'h0000;
		host_abort_pulse <= 1'b0;
		host_board_reset <= 1'b0;
		broadcast_all_boards <= 1'b0;
		probe_vld <= 1'b0;
		clk_en <= 1'b1;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		look("data_oe_n", 16'h0001, port_data_oe_n);
		look("attn_oe_n", 16'h0001, shared_attention_n_oe_n);
		reg_read(hpp_pkg::ADDR_CTRL, "ctrl", 16'h0010, 16'hffff);
		reg_read(4'hf, "unmapped", 16'h0000, 16'hffff);
		for (i = 0; i < 3; i++) begin
			b = rnd8();
			host.host_write(3'h5, b, 1'b1);
			reg_read(hpp_pkg::ADDR_STATUS, "rx_valid", 16'h0100, 16'h0100);
			reg_read(hpp_pkg::ADDR_RXDATA, "rx_byte", {8'h00, b}, 16'h00ff);
		end
		host.host_write(3'h2, ~b, 1'b0);
		reg_read(hpp_pkg::ADDR_STATUS, "rx_other", 16'h0000, 16'h0100);
		// auto-ack off: the write waits for the software acknowledge
		reg_write(hpp_pkg::ADDR_CTRL, 16'h0000);
		reg_read(hpp_pkg::ADDR_CTRL, "ctrl_off", 16'h0000, 16'hffff);
		b = rnd8();
		fork
			host.host_write(3'h5, b, 1'b1);
			begin
				repeat (12) @(posedge core_clk);
				reg_read(hpp_pkg::ADDR_STATUS, "ack_held", 16'h0100, 16'h0102);
				reg_write(hpp_pkg::ADDR_CTRL, 16'h0011);
			end
		join
		reg_read(hpp_pkg::ADDR_RXDATA, "rx_sw", {8'h00, b}, 16'h00ff);
		b = rnd8();
		reg_write(hpp_pkg::ADDR_TXDATA, {8'h00, b});
		host.pick(3'h2);
		reg_write(hpp_pkg::ADDR_CTRL, 16'h0012);
		repeat (6) @(posedge core_clk);
		look("send_unsel", 16'h0000, board_send_request);
		note("tx_byte", {8'h00, b}, 16'h00ff);
		host.host_read(3'h5, 1'b1);
		// a frozen block ignores a data write
		clk_en <= 1'b0;
		reg_write(hpp_pkg::ADDR_TXDATA, {8'h00, ~b});
		clk_en <= 1'b1;
		reg_read(hpp_pkg::ADDR_TXDATA, "tx_frozen", {8'h00, b}, 16'h00ff);
		b = rnd8();
		host.pick(3'h2);
		reg_write(hpp_pkg::ADDR_SVCODE, {8'h00, b});
		reg_write(hpp_pkg::ADDR_CTRL, 16'h0014);
		repeat (6) @(posedge core_clk);
		look("attn_line", 16'h0000, attn);
		look("irq_unsel", 16'h0000, board_irq_request);
		note("svc_code", {8'h00, b}, 16'h00ff);
		host.host_service(3'h5);
		look("attn_clear", 16'h0001, attn);
		reg_read(hpp_pkg::ADDR_STATUS, "svc_once", 16'h0000, 16'h0034);
		for (i = 0; i < 3; i++) begin
			host.pick(i == 0 ? 3'h5 : 3'h2);
			broadcast_all_boards <= (i == 2);
			host_abort_pulse <= 1'b1;
			repeat (4) @(posedge core_clk);
			host_abort_pulse <= 1'b0;
			repeat (12) @(posedge core_clk);
			reg_read(hpp_pkg::ADDR_STATUS, "abort", {9'h000, i != 1, 6'h00}, 16'h0040);
			reg_write(hpp_pkg::ADDR_CTRL, 16'h0018);
			look("abort_clr", 16'h0000, abort_irq7);
		end
		for (i = 0; i < 4; i++) begin
			host.pick(i < 2 ? 3'h5 : 3'h2);
			broadcast_all_boards <= (i == 2);
			host_board_reset <= 1'b1;
			repeat (i == 0 ? 10 : 40) @(posedge core_clk);
			look("board_reset", {15'h0000, i == 1 || i == 2}, board_reset_out);
			host_board_reset <= 1'b0;
			repeat (8) @(posedge core_clk);
			look("reset_end", 16'h0000, board_reset_out);
		end
		look("host_wait", 16'h0000, fault);
		give_verdict();
	end
endmodule : tb_top
